// ==== design/cnf_consts.svh ====
// Constants for the configurable native queue: register offsets, field
// positions, reset values. Assumes inclusion by the queue package users.
// Function
// - Separate write and read clocks are synchronised inside the queue itself; this queue runs both sides on mclk
// - Look-ahead mode shows the oldest word without any read request
// - Look-ahead offered for block, distributed and macro memory, never shift
// - Write:read width ratios from 1:8 up to 8:1 convert automatically
// - Unequal widths only for block memory with separate clocks
// - Output register adds exactly one cycle to read data and valid
// - Output register resets read data to default or programmed value
// - Output register only for block memory and common-clock macro queues
// - Common-clock memory queues give full, almost and programmable flags
// - Write acknowledge, overflow, valid and underflow offered everywhere
// - Common-clock memory queues may output the held word count
// - Block and distributed common-clock queues choose sync or async reset
// - Common-clock macro queue: full, empty, programmable flags, no almost
// - Separate-clock macro queue: full, empty and programmable flags
// - Read side runs on read clock, write side on write clock; here both sides run on mclk
// - Separate-clock memory queues give write-side and read-side word counts
// - Error inject and check only for block and macro queues
// - Macro queues do not build the missing almost flags; they stay low
// - Write while full is ignored and leaves contents intact
// - Acknowledge follows accepted write, overflow follows refused write
// - Almost full when exactly one more write fits
`ifndef CNF_CONSTS_SVH
`define CNF_CONSTS_SVH

`define CNF_OFF_CTRL     8'h00
`define CNF_OFF_STATUS   8'h04
`define CNF_OFF_PFA      8'h08
`define CNF_OFF_PFN      8'h0c
`define CNF_OFF_PEA      8'h10
`define CNF_OFF_PEN      8'h14
`define CNF_OFF_COUNT    8'h18
`define CNF_OFF_DOUTRST  8'h1c
`define CNF_OFF_ERR      8'h20

`define CNF_CTRL_LA      0
`define CNF_CTRL_OREG    1
`define CNF_CTRL_FLUSH   2

`define CNF_ERR_OVF      0
`define CNF_ERR_UDF      1
`define CNF_ERR_SBIT     2
`define CNF_ERR_DBIT     3

`define CNF_RST_PFA      16'h000c
`define CNF_RST_PFN      16'h000a
`define CNF_RST_PEA      16'h0002
`define CNF_RST_PEN      16'h0004
`define CNF_RST_DOUT     32'h00000000

`endif

// ==== design/cnf_pkg.sv ====
// Types for the configurable native queue.
// Assumes nothing beyond a SystemVerilog compiler.
package cnf_pkg;

  typedef enum logic [3:0] {
    CNF_MEM_BLOCK = 4'h1,
    CNF_MEM_DIST  = 4'h2,
    CNF_MEM_SHIFT = 4'h4,
    CNF_MEM_MACRO = 4'h8
  } cnf_mem_e;

  typedef struct packed {
    logic full;
    logic almost_full;
    logic prog_full;
    logic wr_ack;
    logic overflow;
  } cnf_wr_flags_s;

  typedef struct packed {
    logic empty;
    logic almost_empty;
    logic prog_empty;
    logic valid;
    logic underflow;
    logic sbit_err;
    logic dbit_err;
  } cnf_rd_flags_s;

endpackage

// ==== design/cnf_fifo.sv ====
// Configurable native queue with Avalon-MM control registers.
// Assumes producer and consumer logic both run on mclk.
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cnf_consts.svh"

module cnf_fifo
  import cnf_pkg::*;
#(
  parameter int       DATA_W    = 8,
  parameter int       DEPTH     = 16,
  parameter int       WR_MULT   = 1,
  parameter int       RD_MULT   = 1,
  parameter cnf_mem_e MEM_KIND  = CNF_MEM_BLOCK,
  parameter bit       INDEP_CLK = 1'b0,
  parameter bit       SYNC_RST  = 1'b0,
  parameter bit       ECC_EN    = 1'b1,
  parameter bit       HAS_COUNT = 1'b1
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        wr_en,
  input  wire logic [DATA_W*WR_MULT-1:0]   din,
  input  wire logic                        inject_sbit_err,
  input  wire logic                        inject_dbit_err,
  output cnf_wr_flags_s                    wr_flags,
  output logic      [15:0]                 wr_data_count,
  input  wire logic                        rd_en,
  output logic      [DATA_W*RD_MULT-1:0]   dout,
  output cnf_rd_flags_s                    rd_flags,
  output logic      [15:0]                 rd_data_count
);

  localparam int AW  = $clog2(DEPTH);
  localparam int CW  = AW + 1;
  localparam bit RATIO_OK = (MEM_KIND == CNF_MEM_BLOCK) && INDEP_CLK;
  localparam int WM  = RATIO_OK ? WR_MULT : 1;
  localparam int RM  = RATIO_OK ? RD_MULT : 1;
  localparam int RD_W = DATA_W * RD_MULT;
  localparam int WSH = $clog2(WM);
  localparam int RSH = $clog2(RM);
  localparam bit LA_OK    = (MEM_KIND != CNF_MEM_SHIFT);
  localparam bit OREG_OK  = (MEM_KIND == CNF_MEM_BLOCK) ||
                            ((MEM_KIND == CNF_MEM_MACRO) && !INDEP_CLK);
  localparam bit ALM_OK   = (MEM_KIND != CNF_MEM_MACRO);
  localparam bit CNT_OK   = HAS_COUNT && (MEM_KIND != CNF_MEM_MACRO);
  localparam bit ECC_OK   = ECC_EN && ((MEM_KIND == CNF_MEM_BLOCK) ||
                                       (MEM_KIND == CNF_MEM_MACRO));
  localparam bit SRST_OK  = SYNC_RST && !INDEP_CLK &&
                            ((MEM_KIND == CNF_MEM_BLOCK) || (MEM_KIND == CNF_MEM_DIST));
  localparam logic [CW-1:0] WMC    = CW'(WM);
  localparam logic [CW-1:0] RMC    = CW'(RM);
  localparam logic [CW-1:0] FULL_T = CW'(DEPTH - WM);
  localparam logic [CW-1:0] AF_T   = CW'(DEPTH - 2 * WM);

  // Check bits: p0 over all bits, p1 over odd positions
  function automatic logic [DATA_W+1:0] enc(input logic [DATA_W-1:0] d,
                                           input logic sb, input logic db);
    logic [DATA_W-1:0] odd;
    logic [DATA_W-1:0] f;
    odd = '0;
    for (int i = 1; i < DATA_W; i += 2) odd[i] = 1'b1;
    f = d;
    f[0] = d[0] ^ (sb | db);
    f[1] = d[1] ^ db;
    return {^(d & odd), ^d, f};
  endfunction

  logic [DATA_W+1:0]  mem [DEPTH];
  logic [AW-1:0]      wptr;
  logic [AW-1:0]      rptr;
  logic [CW-1:0]      count;
  logic [CW-1:0]      next_count;
  logic               la_full;
  logic               next_la_full;
  logic               ctrl_la;
  logic               ctrl_oreg;
  logic               soft_flush;
  logic               srst_q;
  logic               flush;
  logic [15:0]        pfa;
  logic [15:0]        pfn;
  logic [15:0]        pea;
  logic [15:0]        pen;
  logic [31:0]        dout_rst;
  logic [3:0]         err_sticky;
  logic [RD_W-1:0]    rd_word;
  logic               rd_sbit;
  logic               rd_dbit;
  logic [RD_W-1:0]    s1_data;
  logic               s1_valid;
  logic               s1_sbit;
  logic               s1_dbit;
  logic               mode_la;
  logic               mode_oreg;
  logic               wr_ok;
  logic               pop;
  logic               rd_ok;
  logic [15:0]        next_wcnt;
  logic [15:0]        next_rcnt;
  logic               bus_go;

  assign mode_la   = ctrl_la && LA_OK;
  assign mode_oreg = ctrl_oreg && OREG_OK && !mode_la;
  assign wr_ok     = wr_en && !wr_flags.full;
  assign pop       = (count >= RMC) && (mode_la ? (!la_full || rd_en) : rd_en);
  assign rd_ok     = mode_la ? (rd_en && la_full) : pop;
  assign flush     = soft_flush || (SRST_OK && srst_q);
  assign bus_go    = (avs_read || avs_write) && !avs_waitrequest;

  // Both sides share mclk, so pointers need no crossing logic
  always_comb begin
    next_count = count;
    if (wr_ok) next_count = next_count + WMC;
    if (pop) next_count = next_count - RMC;
    if (flush) next_count = '0;
  end

  always_comb begin
    next_la_full = la_full;
    if (pop) next_la_full = 1'b1;
    else if (rd_ok) next_la_full = 1'b0;
    if (!mode_la || flush) next_la_full = 1'b0;
  end

  always_comb begin
    next_wcnt = 16'(next_count >> WSH);
    next_rcnt = 16'(next_count >> RSH) + {15'h0000, next_la_full};
  end

  // Gathers RM units into one read word, lowest unit first
  always_comb begin
    logic [DATA_W+1:0] e;
    e = '0;
    rd_word = '0;
    rd_sbit = 1'b0;
    rd_dbit = 1'b0;
    for (int i = 0; i < RM; i++) begin
      e = mem[AW'(rptr + AW'(i))];
      rd_word[i*DATA_W +: DATA_W] = e[DATA_W-1:0];
      if (ECC_OK) begin
        if (enc(e[DATA_W-1:0], 1'b0, 1'b0) != e) begin
          if (e[DATA_W] != ^e[DATA_W-1:0]) rd_sbit = 1'b1;
          else rd_dbit = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (wr_ok) begin
      for (int i = 0; i < WM; i++) begin
        mem[AW'(wptr + AW'(i))] <= enc(din[i*DATA_W +: DATA_W],
                                       ECC_OK && inject_sbit_err && i == 0,
                                       ECC_OK && inject_dbit_err && i == 0);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      srst_q <= 1'b1;
    end else begin
      srst_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wptr    <= '0;
      rptr    <= '0;
      count   <= '0;
      la_full <= 1'b0;
    end else begin
      count   <= next_count;
      la_full <= next_la_full;
      if (flush) begin
        wptr <= '0;
        rptr <= '0;
      end else begin
        if (wr_ok) wptr <= AW'(wptr + AW'(WM));
        if (pop) rptr <= AW'(rptr + AW'(RM));
      end
    end
  end

  // Write-side flags; full, almost and programmable built from the word count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_flags      <= '0;
      wr_data_count <= '0;
    end else begin
      wr_flags.full        <= next_count > FULL_T;
      wr_flags.almost_full <= ALM_OK && next_count > AF_T &&
                              next_count <= FULL_T;
      wr_flags.wr_ack      <= wr_ok && !flush;
      wr_flags.overflow    <= wr_en && !wr_ok && !flush;
      if (flush) wr_flags.prog_full <= 1'b0;
      else if (next_wcnt >= pfa) wr_flags.prog_full <= 1'b1;
      else if (next_wcnt < pfn) wr_flags.prog_full <= 1'b0;
      wr_data_count <= CNT_OK ? next_wcnt : 16'h0000;
    end
  end

  // Read-side flags and counts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_flags.empty        <= 1'b1;
      rd_flags.almost_empty <= 1'b0;
      rd_flags.prog_empty   <= 1'b1;
      rd_flags.underflow    <= 1'b0;
      rd_data_count         <= '0;
    end else begin
      rd_flags.empty        <= mode_la ? !next_la_full : next_count < RMC;
      rd_flags.almost_empty <= ALM_OK && next_rcnt == 16'h0001;
      rd_flags.underflow    <= rd_en && !rd_ok && !flush;
      if (flush) rd_flags.prog_empty <= 1'b1;
      else if (next_rcnt <= pea) rd_flags.prog_empty <= 1'b1;
      else if (next_rcnt > pen) rd_flags.prog_empty <= 1'b0;
      rd_data_count <= CNT_OK ? next_rcnt : 16'h0000;
    end
  end

  // First stage used when the output register is on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_data  <= RD_W'(`CNF_RST_DOUT);
      s1_valid <= 1'b0;
      s1_sbit  <= 1'b0;
      s1_dbit  <= 1'b0;
    end else if (flush) begin
      s1_data  <= RD_W'(dout_rst);
      s1_valid <= 1'b0;
      s1_sbit  <= 1'b0;
      s1_dbit  <= 1'b0;
    end else begin
      s1_valid <= pop && !mode_la;
      if (pop) begin
        s1_data <= rd_word;
        s1_sbit <= rd_sbit;
        s1_dbit <= rd_dbit;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout              <= RD_W'(`CNF_RST_DOUT);
      rd_flags.valid    <= 1'b0;
      rd_flags.sbit_err <= 1'b0;
      rd_flags.dbit_err <= 1'b0;
    end else if (flush) begin
      dout              <= RD_W'(dout_rst);
      rd_flags.valid    <= 1'b0;
      rd_flags.sbit_err <= 1'b0;
      rd_flags.dbit_err <= 1'b0;
    end else if (mode_oreg) begin
      rd_flags.valid <= s1_valid;
      if (s1_valid) begin
        dout              <= s1_data;
        rd_flags.sbit_err <= s1_sbit;
        rd_flags.dbit_err <= s1_dbit;
      end
    end else begin
      rd_flags.valid <= mode_la ? next_la_full : pop;
      if (pop) begin
        dout              <= rd_word;
        rd_flags.sbit_err <= rd_sbit;
        rd_flags.dbit_err <= rd_dbit;
      end
    end
  end

  // Avalon slave: one wait cycle, then the access takes effect
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        if (avs_address == `CNF_OFF_CTRL)
          avs_readdata <= {30'h00000000, ctrl_oreg, ctrl_la};
        else if (avs_address == `CNF_OFF_STATUS)
          avs_readdata <= {24'h000000, rd_flags.dbit_err, rd_flags.sbit_err,
                           rd_flags.prog_empty, wr_flags.prog_full,
                           rd_flags.almost_empty, wr_flags.almost_full,
                           rd_flags.empty, wr_flags.full};
        else if (avs_address == `CNF_OFF_PFA) avs_readdata <= {16'h0000, pfa};
        else if (avs_address == `CNF_OFF_PFN) avs_readdata <= {16'h0000, pfn};
        else if (avs_address == `CNF_OFF_PEA) avs_readdata <= {16'h0000, pea};
        else if (avs_address == `CNF_OFF_PEN) avs_readdata <= {16'h0000, pen};
        else if (avs_address == `CNF_OFF_COUNT)
          avs_readdata <= {rd_data_count, wr_data_count};
        else if (avs_address == `CNF_OFF_DOUTRST) avs_readdata <= dout_rst;
        else if (avs_address == `CNF_OFF_ERR)
          avs_readdata <= {28'h0000000, err_sticky};
        else avs_readdata <= 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_la    <= 1'b0;
      ctrl_oreg  <= 1'b0;
      soft_flush <= 1'b0;
      pfa        <= `CNF_RST_PFA;
      pfn        <= `CNF_RST_PFN;
      pea        <= `CNF_RST_PEA;
      pen        <= `CNF_RST_PEN;
      dout_rst   <= `CNF_RST_DOUT;
    end else begin
      soft_flush <= 1'b0;
      if (bus_go && avs_write) begin
        if (avs_address == `CNF_OFF_CTRL) begin
          ctrl_la    <= avs_writedata[`CNF_CTRL_LA];
          ctrl_oreg  <= avs_writedata[`CNF_CTRL_OREG];
          soft_flush <= avs_writedata[`CNF_CTRL_FLUSH];
        end
        else if (avs_address == `CNF_OFF_PFA) pfa <= avs_writedata[15:0];
        else if (avs_address == `CNF_OFF_PFN) pfn <= avs_writedata[15:0];
        else if (avs_address == `CNF_OFF_PEA) pea <= avs_writedata[15:0];
        else if (avs_address == `CNF_OFF_PEN) pen <= avs_writedata[15:0];
        else if (avs_address == `CNF_OFF_DOUTRST) dout_rst <= avs_writedata;
      end
    end
  end

  // Sticky error bits: write one to clear, a new event wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err_sticky <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (bus_go && avs_write && avs_address == `CNF_OFF_ERR &&
            avs_writedata[i])
          err_sticky[i] <= 1'b0;
      end
      if (wr_flags.overflow) err_sticky[`CNF_ERR_OVF] <= 1'b1;
      if (rd_flags.underflow) err_sticky[`CNF_ERR_UDF] <= 1'b1;
      if (rd_flags.sbit_err) err_sticky[`CNF_ERR_SBIT] <= 1'b1;
      if (rd_flags.dbit_err) err_sticky[`CNF_ERR_DBIT] <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_wr_refused;
    wr_en && wr_flags.full && !flush;
  endsequence

  sequence s_wr_taken;
    wr_en && !wr_flags.full && !flush;
  endsequence

  sequence s_std_pop;
    !mode_la && !mode_oreg && !flush && pop;
  endsequence

  sequence s_oreg_pop;
    (mode_oreg && !flush && pop) ##1 (mode_oreg && !flush);
  endsequence

  full_ignore_a: assert property (s_wr_refused |=> $stable(wptr))
    else $error("write pointer moved on a write while full");

  wr_ack_a: assert property (s_wr_taken |=> wr_flags.wr_ack && !wr_flags.overflow)
    else $error("accepted write not acknowledged");

  overflow_a: assert property (s_wr_refused |=> wr_flags.overflow && !wr_flags.wr_ack)
    else $error("refused write did not raise overflow");

  almost_full_a: assert property (wr_flags.almost_full |->
      (count > AF_T) && (count <= FULL_T) && !wr_flags.full)
    else $error("almost full outside the one-write window");

  underflow_a: assert property ((rd_en && !rd_ok && !flush) |=>
      rd_flags.underflow && (rptr == AW'($past(rptr) + ($past(pop) ? RM : 0))))
    else $error("empty read not flagged or pointer moved");

  std_valid_a: assert property ((!mode_la && !mode_oreg && !flush) |=>
      (rd_flags.valid == $past(pop)))
    else $error("valid does not follow accepted read");

  std_data_a: assert property (s_std_pop |=> (dout == $past(rd_word)))
    else $error("read data not the popped word");

  oreg_delay_a: assert property (s_oreg_pop |=> rd_flags.valid)
    else $error("output register did not delay valid by one cycle");

  lookahead_a: assert property ((mode_la && !flush && count >= RMC && !la_full) |=>
      rd_flags.valid ##0 !rd_flags.empty)
    else $error("look-ahead word not presented");

endmodule // cnf_fifo

`default_nettype wire

// ==== tb/cnf_user_model.sv ====
// Producer and consumer logic on the native write and read ports.
// Assumes the queue runs on mclk; the bench calls put and get.
`timescale 1ns/1ps
`default_nettype none
module cnf_user_model
  import cnf_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic          mclk,
  output logic               wr_en,
  output logic [W-1:0]       din,
  output logic               rd_en,
  input  wire cnf_wr_flags_s wr_flags,
  input  wire cnf_rd_flags_s rd_flags,
  input  wire logic [W-1:0]  dout
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    din   = '0;
  end
  // One write request; data inverted once released
  task automatic put(input logic [W-1:0] d, output logic ack, output logic ovf);
    @(posedge mclk);
    wr_en <= 1'b1;
    din   <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    din   <= ~d;
    #1;
    ack = wr_flags.wr_ack;
    ovf = wr_flags.overflow;
  endtask
  // One read request; lat extra edges before data is taken
  task automatic get(input int lat, output logic vf, output logic v,
                     output logic [W-1:0] d, output logic u);
    @(posedge mclk);
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    u  = rd_flags.underflow;
    vf = rd_flags.valid;
    repeat (lat) begin
      @(posedge mclk);
      #1;
    end
    v = rd_flags.valid;
    d = dout;
  endtask
endmodule // cnf_user_model
`default_nettype wire

// ==== tb/cnf_fifo_bench.sv ====
// Self-checking bench for the native queue and its register bus.
// Assumes default build parameters: 8-bit words, 16 deep, one clock.
`timescale 1ns/1ps
`default_nettype none
`include "cnf_consts.svh"
module cnf_fifo_bench
  import cnf_pkg::*;
;
  logic          mclk, rst, wr_en, rd_en, avs_read, avs_write, avs_waitrequest;
  logic          inject_sbit_err, inject_dbit_err;
  logic [7:0]    avs_address, din, dout;
  logic [31:0]   avs_writedata, avs_readdata, rv;
  logic [15:0]   wr_data_count, rd_data_count;
  cnf_wr_flags_s wr_flags;
  cnf_rd_flags_s rd_flags;
  logic          ack, ovf, vf, v, u;
  logic [7:0]    d;
  int            bad_count, n_compared;
  logic [7:0]    ra [6] = '{`CNF_OFF_PFA, `CNF_OFF_PFN, `CNF_OFF_PEA, `CNF_OFF_PEN,
                            `CNF_OFF_DOUTRST, 8'h3c};
  logic [31:0]   rx [6] = '{32'h0000000c, 32'h0000000a, 32'h00000002, 32'h00000004,
                            32'h00000000, 32'h00000000};

  cnf_fifo cnf_fifo_i (
    .mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wr_en(wr_en), .din(din),
    .inject_sbit_err(inject_sbit_err), .inject_dbit_err(inject_dbit_err),
    .wr_flags(wr_flags), .wr_data_count(wr_data_count), .rd_en(rd_en), .dout(dout),
    .rd_flags(rd_flags), .rd_data_count(rd_data_count)
  );
  cnf_user_model cnf_user_model_i (
    .mclk(mclk), .wr_en(wr_en), .din(din), .rd_en(rd_en),
    .wr_flags(wr_flags), .rd_flags(rd_flags), .dout(dout)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !wr;
    avs_write     <= wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    give_verdict();
  end

  initial begin
    bad_count = 0;
    n_compared = 0;
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    inject_sbit_err = 1'b0;
    inject_dbit_err = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check(rd_flags.empty, 1);
    check(wr_flags.full, 0);
    check(rd_flags.prog_empty, 1);
    check(wr_data_count, 0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 32'h0, rv);
      check(rv, rx[i]);
    end
    // Read while empty
    cnf_user_model_i.get(0, vf, v, d, u);
    check(u, 1);
    check(v, 0);
    check(rd_data_count, 0);
    bus(1'b0, `CNF_OFF_ERR, 32'h0, rv);
    check(rv[1], 1);
    bus(1'b1, `CNF_OFF_ERR, 32'h3, rv);
    // Fill to full, then one refused write
    for (int i = 0; i < 16; i++) begin
      cnf_user_model_i.put(8'h10 + 8'(i), ack, ovf);
      check(ack, 1);
      check(ovf, 0);
      check(wr_flags.almost_full, i == 14);
      check(wr_flags.full, i == 15);
      check(wr_flags.prog_full, i >= 11);
      check(wr_data_count, i + 1);
    end
    cnf_user_model_i.put(8'hee, ack, ovf);
    check(ack, 0);
    check(ovf, 1);
    check(wr_data_count, 16);
    bus(1'b0, `CNF_OFF_ERR, 32'h0, rv);
    check(rv[0], 1);
    bus(1'b0, `CNF_OFF_STATUS, 32'h0, rv);
    check(rv, 32'h00000011);
    bus(1'b0, `CNF_OFF_COUNT, 32'h0, rv);
    check(rv, 32'h00100010);
    // Drain with one read every other cycle, oldest first
    for (int i = 0; i < 16; i++) begin
      cnf_user_model_i.get(0, vf, v, d, u);
      check(v, 1);
      check(d, 8'h10 + 8'(i));
      check(rd_flags.empty, i == 15);
      check(rd_flags.almost_empty, i == 14);
      check(rd_flags.prog_empty, i >= 13);
      check(wr_flags.prog_full, i < 6);
    end
    // Output register adds one cycle
    bus(1'b1, `CNF_OFF_CTRL, 32'h2, rv);
    bus(1'b0, `CNF_OFF_CTRL, 32'h0, rv);
    check(rv, 32'h00000002);
    cnf_user_model_i.put(8'h33, ack, ovf);
    cnf_user_model_i.get(1, vf, v, d, u);
    check(vf, 0);
    check(v, 1);
    check(d, 8'h33);
    // Look-ahead shows the word unasked
    bus(1'b1, `CNF_OFF_CTRL, 32'h1, rv);
    cnf_user_model_i.put(8'h5a, ack, ovf);
    repeat (3) @(posedge mclk);
    #1;
    check(dout, 8'h5a);
    check(rd_flags.valid, 1);
    check(rd_flags.empty, 0);
    cnf_user_model_i.get(0, vf, v, d, u);
    check(rd_flags.empty, 1);
    // Flush loads the programmed output value
    bus(1'b1, `CNF_OFF_CTRL, 32'h0, rv);
    bus(1'b1, `CNF_OFF_DOUTRST, 32'ha5, rv);
    cnf_user_model_i.put(8'h77, ack, ovf);
    bus(1'b1, `CNF_OFF_CTRL, 32'h4, rv);
    repeat (2) @(posedge mclk);
    #1;
    check(dout, 8'ha5);
    check(rd_flags.empty, 1);
    check(wr_data_count, 0);
    // Injected errors are flagged and left uncorrected
    @(posedge mclk);
    inject_sbit_err <= 1'b1;
    cnf_user_model_i.put(8'h40, ack, ovf);
    @(posedge mclk);
    inject_sbit_err <= 1'b0;
    inject_dbit_err <= 1'b1;
    cnf_user_model_i.put(8'h40, ack, ovf);
    @(posedge mclk);
    inject_dbit_err <= 1'b0;
    cnf_user_model_i.get(0, vf, v, d, u);
    check(d, 8'h41);
    check(rd_flags.sbit_err, 1);
    check(rd_flags.dbit_err, 0);
    cnf_user_model_i.get(0, vf, v, d, u);
    check(d, 8'h43);
    check(rd_flags.dbit_err, 1);
    check(rd_flags.sbit_err, 0);
    bus(1'b0, `CNF_OFF_ERR, 32'h0, rv);
    check(rv[3:2], 2'b11);
    give_verdict();
  end
endmodule // cnf_fifo_bench
`default_nettype wire
